// ===== pkg/ssr_defs.vh
// Purpose: shared constants of the status reporting block
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH

`define SSR_W          16
`define SSR_MSB_MASK   16'h7fff

// register select codes on the command port
`define SSR_REG_OPER   3'h0
`define SSR_REG_QUES   3'h1
`define SSR_REG_ESR    3'h2
`define SSR_REG_STB    3'h3
`define SSR_REG_SRE    3'h4

// part select codes
`define SSR_PART_COND  3'h0
`define SSR_PART_PTR   3'h1
`define SSR_PART_NTR   3'h2
`define SSR_PART_EVT   3'h3
`define SSR_PART_ENA   3'h4

// reset values
`define SSR_PTR_RST    16'h7fff
`define SSR_NTR_RST    16'h0000
`define SSR_ENA_RST    16'h0000
`define SSR_EVT_RST    16'h0000
`define SSR_SRE_RST    8'h00
`define SSR_STB_RST    8'h00

// status byte bit positions
`define SSR_STB_EQ     2
`define SSR_STB_QUES   3
`define SSR_STB_MAV    4
`define SSR_STB_ESB    5
`define SSR_STB_MSS    6
`define SSR_STB_OPER   7
`define SSR_SRE_GATE   8'hbf

// operation register bit carrying calibration status
`define SSR_OPER_CAL   0

`endif

// ===== rtl/ssr_scpi_reg.v
// Purpose: one five-part status register with edge filters and sum bit
// Assumes: i_cond comes from logic on i_ref_clk
// Notes:   bit 15 of every part is held at zero
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_scpi_reg #(
  parameter W = `SSR_W
) (
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst,
  // live condition
  input  wire [W-1:0] i_cond,
  // access
  input  wire         i_wr,
  input  wire [2:0]   i_part,
  input  wire [W-1:0] i_wdata,
  input  wire         i_evt_clr,
  // parts and summary
  output wire [W-1:0] o_cond,
  output wire [W-1:0] o_ptr,
  output wire [W-1:0] o_ntr,
  output wire [W-1:0] o_evt,
  output wire [W-1:0] o_ena,
  output wire         o_sum
);

  wire [W-1:0] mask = {1'b0, {(W-1){1'b1}}};
  reg  [W-1:0] cond_r;
  reg  [W-1:0] ptr_r;
  reg  [W-1:0] ntr_r;
  reg  [W-1:0] evt_r;
  reg  [W-1:0] ena_r;
  wire [W-1:0] cond_now = i_cond & mask;
  wire [W-1:0] rise     = cond_now & ~cond_r;
  wire [W-1:0] fall     = ~cond_now & cond_r;
  wire [W-1:0] evt_nxt;

  // only filtered edges set events; set wins over the read clear
  assign evt_nxt = ((evt_r & ~{W{i_evt_clr}})
                   | (rise & ptr_r)
                   | (fall & ntr_r)) & mask;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      cond_r <= {W{1'b0}};
      ptr_r  <= `SSR_PTR_RST;
      ntr_r  <= `SSR_NTR_RST;
      evt_r  <= `SSR_EVT_RST;
      ena_r  <= `SSR_ENA_RST;
    end else begin
      cond_r <= cond_now;
      evt_r  <= evt_nxt;
      if (i_wr && i_part == `SSR_PART_PTR) begin
        ptr_r <= i_wdata & mask;
      end
      if (i_wr && i_part == `SSR_PART_NTR) begin
        ntr_r <= i_wdata & mask;
      end
      if (i_wr && i_part == `SSR_PART_ENA) begin
        ena_r <= i_wdata & mask;
      end
    end
  end

  assign o_cond = cond_r;
  assign o_ptr  = ptr_r;
  assign o_ntr  = ntr_r;
  assign o_evt  = evt_r;
  assign o_ena  = ena_r;
  assign o_sum  = |(evt_r & ena_r);

endmodule // ssr_scpi_reg

// ===== rtl/ssr_stb.v
// Purpose: status byte, service request enable and service request
// Assumes: summary inputs come from logic on i_ref_clk
// Notes:   o_srq is a one-cycle pulse
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_stb (
  // clock and reset
  input  wire       i_ref_clk,
  input  wire       i_rst,
  // sources
  input  wire       i_err_nonempty,
  input  wire       i_ques_sum,
  input  wire       i_msg_avail,
  input  wire       i_esb,
  input  wire       i_oper_sum,
  // enable mask access
  input  wire       i_sre_wr,
  input  wire [7:0] i_sre_wdata,
  // results
  output reg  [7:0] o_stb,
  output reg  [7:0] o_sre,
  output reg        o_srq
);

  reg [7:0] base;
  reg [7:0] stb_nxt;
  reg       srq_nxt;

  always @* begin
    base                = 8'h00;  // bits 0 and 1 stay unused
    base[`SSR_STB_EQ]   = i_err_nonempty;
    base[`SSR_STB_QUES] = i_ques_sum;
    base[`SSR_STB_MAV]  = i_msg_avail;
    base[`SSR_STB_ESB]  = i_esb;
    base[`SSR_STB_OPER] = i_oper_sum;
    stb_nxt             = base;
    // mss summarises the enabled bits; sre bit 6 never gates
    stb_nxt[`SSR_STB_MSS] = |(base & o_sre & `SSR_SRE_GATE);
    srq_nxt = |(base & ~o_stb & o_sre & `SSR_SRE_GATE);
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_stb <= `SSR_STB_RST;
      o_sre <= `SSR_SRE_RST;
      o_srq <= 1'b0;
    end else begin
      o_stb <= stb_nxt;
      o_srq <= srq_nxt;
      if (i_sre_wr) begin
        o_sre <= i_sre_wdata;
      end
    end
  end

endmodule // ssr_stb

// ===== rtl/ssr_top.v
// Purpose: hierarchical status reporting with service request output
// Assumes: command port and status inputs come from logic on i_ref_clk
// Notes:   registers are reached through the query command port; o_stb and o_sre are also driven out directly
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_top #(
  parameter W = `SSR_W
) (
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst,
  // hardware status
  input  wire         i_cal_busy,
  input  wire [W-1:0] i_oper_status,
  input  wire [W-1:0] i_ques_status,
  input  wire [W-1:0] i_esr_status,
  input  wire         i_err_nonempty,
  input  wire         i_outbuf_nonempty,
  // query command port
  input  wire         i_cmd_valid,
  input  wire         i_cmd_wr,
  input  wire [2:0]   i_cmd_reg,
  input  wire [2:0]   i_cmd_part,
  input  wire [W-1:0] i_cmd_wdata,
  input  wire         i_serial_poll,
  // responses
  output reg          o_rsp_valid,
  output reg  [W-1:0] o_rsp_data,
  output reg          o_cmd_err,
  // service request and status byte
  output wire         o_srq,
  output wire [7:0]   o_stb,
  output wire [7:0]   o_sre
);

  // picks one of the five parts of a register
  function [W-1:0] pick_part;
    input [2:0]   part;
    input [W-1:0] cond;
    input [W-1:0] ptr;
    input [W-1:0] ntr;
    input [W-1:0] evt;
    input [W-1:0] ena;
    begin
      case (part)
        `SSR_PART_COND: pick_part = cond;
        `SSR_PART_PTR:  pick_part = ptr;
        `SSR_PART_NTR:  pick_part = ntr;
        `SSR_PART_EVT:  pick_part = evt;
        `SSR_PART_ENA:  pick_part = ena;
        default:        pick_part = {W{1'b0}};
      endcase
    end
  endfunction

  // true when a part may be written
  function part_writable;
    input [2:0] part;
    begin
      part_writable = (part == `SSR_PART_PTR) ||
                      (part == `SSR_PART_NTR) ||
                      (part == `SSR_PART_ENA);
    end
  endfunction

  // true when a part code names one of the five parts
  function part_valid;
    input [2:0] part;
    begin
      part_valid = (part <= `SSR_PART_ENA);
    end
  endfunction

  // command decode; a serial poll takes the cycle and refuses a command
  wire cmd_ok   = i_cmd_valid & ~i_serial_poll;
  wire cmd_rd   = cmd_ok & ~i_cmd_wr;
  wire cmd_wr   = cmd_ok & i_cmd_wr;
  wire sel_oper = (i_cmd_reg == `SSR_REG_OPER);
  wire sel_ques = (i_cmd_reg == `SSR_REG_QUES);
  wire sel_esr  = (i_cmd_reg == `SSR_REG_ESR);
  wire sel_stb  = (i_cmd_reg == `SSR_REG_STB);
  wire sel_sre  = (i_cmd_reg == `SSR_REG_SRE);
  wire sel_scpi = sel_oper | sel_ques | sel_esr;
  wire wr_scpi  = cmd_wr & part_writable(i_cmd_part);
  wire evt_rd   = cmd_rd & (i_cmd_part == `SSR_PART_EVT);

  // per-register part buses
  wire [W-1:0] oper_cond;
  wire [W-1:0] oper_ptr;
  wire [W-1:0] oper_ntr;
  wire [W-1:0] oper_evt;
  wire [W-1:0] oper_ena;
  wire         oper_sum;
  wire [W-1:0] ques_cond;
  wire [W-1:0] ques_ptr;
  wire [W-1:0] ques_ntr;
  wire [W-1:0] ques_evt;
  wire [W-1:0] ques_ena;
  wire         ques_sum;
  wire [W-1:0] esr_cond;
  wire [W-1:0] esr_ptr;
  wire [W-1:0] esr_ntr;
  wire [W-1:0] esr_evt;
  wire [W-1:0] esr_ena;
  wire         esr_sum;

  // calibration status replaces operation bit 0
  reg [W-1:0] oper_live;
  always @* begin
    oper_live                 = i_oper_status;
    oper_live[`SSR_OPER_CAL]  = i_cal_busy;
  end

  ssr_scpi_reg #(
    .W (W)
  ) u_oper (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_cond    (oper_live),
    .i_wr      (wr_scpi & sel_oper),
    .i_part    (i_cmd_part),
    .i_wdata   (i_cmd_wdata),
    .i_evt_clr (evt_rd & sel_oper),
    .o_cond    (oper_cond),
    .o_ptr     (oper_ptr),
    .o_ntr     (oper_ntr),
    .o_evt     (oper_evt),
    .o_ena     (oper_ena),
    .o_sum     (oper_sum)
  );

  ssr_scpi_reg #(
    .W (W)
  ) u_ques (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_cond    (i_ques_status),
    .i_wr      (wr_scpi & sel_ques),
    .i_part    (i_cmd_part),
    .i_wdata   (i_cmd_wdata),
    .i_evt_clr (evt_rd & sel_ques),
    .o_cond    (ques_cond),
    .o_ptr     (ques_ptr),
    .o_ntr     (ques_ntr),
    .o_evt     (ques_evt),
    .o_ena     (ques_ena),
    .o_sum     (ques_sum)
  );

  // the standard event register uses the same five-part structure
  ssr_scpi_reg #(
    .W (W)
  ) u_esr (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_cond    (i_esr_status),
    .i_wr      (wr_scpi & sel_esr),
    .i_part    (i_cmd_part),
    .i_wdata   (i_cmd_wdata),
    .i_evt_clr (evt_rd & sel_esr),
    .o_cond    (esr_cond),
    .o_ptr     (esr_ptr),
    .o_ntr     (esr_ntr),
    .o_evt     (esr_evt),
    .o_ena     (esr_ena),
    .o_sum     (esr_sum)
  );

  // summaries become condition bits of the status byte
  ssr_stb u_stb (
    .i_ref_clk      (i_ref_clk),
    .i_rst          (i_rst),
    .i_err_nonempty (i_err_nonempty),
    .i_ques_sum     (ques_sum),
    .i_msg_avail    (i_outbuf_nonempty),
    .i_esb          (esr_sum),
    .i_oper_sum     (oper_sum),
    .i_sre_wr       (cmd_wr & sel_sre),
    .i_sre_wdata    (i_cmd_wdata[7:0]),
    .o_stb          (o_stb),
    .o_sre          (o_sre),
    .o_srq          (o_srq)
  );

  // read data and refusal decode
  reg [W-1:0] rd_data;
  reg         bad_cmd;
  always @* begin
    rd_data = {W{1'b0}};
    bad_cmd = 1'b0;
    if (i_serial_poll) begin
      rd_data = {{(W-8){1'b0}}, o_stb};
      bad_cmd = i_cmd_valid;
    end else if (cmd_ok) begin
      if (sel_oper) begin
        rd_data = pick_part(i_cmd_part, oper_cond, oper_ptr,
                            oper_ntr, oper_evt, oper_ena);
      end else if (sel_ques) begin
        rd_data = pick_part(i_cmd_part, ques_cond, ques_ptr,
                            ques_ntr, ques_evt, ques_ena);
      end else if (sel_esr) begin
        rd_data = pick_part(i_cmd_part, esr_cond, esr_ptr,
                            esr_ntr, esr_evt, esr_ena);
      end else if (sel_stb) begin
        rd_data = {{(W-8){1'b0}}, o_stb};
      end else if (sel_sre) begin
        rd_data = {{(W-8){1'b0}}, o_sre};
      end
      if (sel_scpi) begin
        bad_cmd = ~part_valid(i_cmd_part) |
                  (i_cmd_wr & ~part_writable(i_cmd_part));
      end else if (sel_stb) begin
        bad_cmd = i_cmd_wr;
      end else if (!sel_sre) begin
        bad_cmd = 1'b1;
      end
    end
  end

  // answers come one cycle after the request; writes give no answer
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= {W{1'b0}};
      o_cmd_err   <= 1'b0;
    end else begin
      o_rsp_valid <= i_serial_poll | cmd_rd;
      o_rsp_data  <= rd_data & `SSR_MSB_MASK;
      o_cmd_err   <= bad_cmd;
    end
  end

endmodule // ssr_top

// ===== tb/ssr_top_checker.sv
// Purpose: port assertions for the status reporting top
// Assumes: one clock, sync active-high reset
// Notes:   bound to ssr_top from tb_top
`timescale 1ns/1ps
module ssr_top_checker #(
  parameter W = 16
) (
  // clock, reset and inputs
  input wire         i_ref_clk,
  input wire         i_rst,
  input wire         i_err_nonempty,
  input wire         i_outbuf_nonempty,
  input wire         i_cmd_valid,
  input wire         i_cmd_wr,
  input wire [2:0]   i_cmd_reg,
  input wire [2:0]   i_cmd_part,
  input wire [W-1:0] i_cmd_wdata,
  input wire         i_serial_poll,
  // design outputs
  input wire         o_rsp_valid,
  input wire [W-1:0] o_rsp_data,
  input wire         o_cmd_err,
  input wire         o_srq,
  input wire [7:0]   o_stb,
  input wire [7:0]   o_sre
);
  wire [7:0] wd_lo = i_cmd_wdata[7:0];
  wire       cmd_wr = i_cmd_valid && i_cmd_wr && !i_serial_poll;
  wire       ro_wr = cmd_wr && i_cmd_reg < 3'h3 && i_cmd_part[1:0] == 2'h3;
  wire       cond_wr = cmd_wr && i_cmd_reg < 3'h3 && i_cmd_part == 3'h0;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  query_answer_a: assert property (i_cmd_valid && !i_cmd_wr |=> o_rsp_valid)
    else $error("query not answered");
  poll_data_a: assert property (i_serial_poll |=>
    o_rsp_valid && o_rsp_data == {8'h00, $past(o_stb)})
    else $error("poll answer wrong");
  msb_zero_a: assert property (o_rsp_valid |-> !o_rsp_data[W-1])
    else $error("answer bit 15 set");
  mss_sum_a: assert property ($stable(o_sre) |->
    o_stb[6] == |(o_stb & o_sre & 8'hbf)) else $error("summary bit wrong");
  srq_cause_a: assert property (o_srq |->
    |(o_stb & ~$past(o_stb) & 8'hbf)) else $error("request without rise");
  mav_follow_a: assert property (!$past(i_rst) |->
    o_stb[4] == $past(i_outbuf_nonempty)) else $error("message bit wrong");
  err_follow_a: assert property (!$past(i_rst) |->
    o_stb[2] == $past(i_err_nonempty) && o_stb[1:0] == 2'b00)
    else $error("error bit wrong");
  sre_store_a: assert property (cmd_wr && i_cmd_reg == 3'h4 |=>
    o_sre == $past(wd_lo)) else $error("enable mask not stored");
  ro_refused_a: assert property (cond_wr || ro_wr |=> o_cmd_err)
    else $error("read-only write taken");
  cover property (o_srq);
  cover property (i_serial_poll ##1 o_rsp_valid);
  cover property (cond_wr ##1 o_cmd_err);
endmodule // ssr_top_checker

// ===== tb/ssr_host_model.sv
// Purpose: remote controller issuing commands, queries and polls
// Assumes: answer strobe registered on the take edge, sampled 1 ns after it
// Notes:   released lines carry inverted junk, not the last value
`timescale 1ns/1ps
module ssr_host_model (
  // clock and answers
  input  wire         i_ref_clk,
  input  wire         i_rsp_valid,
  input  wire  [15:0] i_rsp_data,
  // command port
  output logic        o_cmd_valid,
  output logic        o_cmd_wr,
  output logic [2:0]  o_cmd_reg,
  output logic [2:0]  o_cmd_part,
  output logic [15:0] o_cmd_wdata,
  output logic        o_serial_poll
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_wr = 1'b0;
    o_cmd_reg = 3'h0;
    o_cmd_part = 3'h0;
    o_cmd_wdata = 16'h0000;
    o_serial_poll = 1'b0;
  end
  task automatic cmd(input logic wr, input logic [2:0] rg,
                     input logic [2:0] pt, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_wr <= wr;
    o_cmd_reg <= rg;
    o_cmd_part <= pt;
    o_cmd_wdata <= wd;
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_wr <= ~wr;
    o_cmd_reg <= ~rg;
    o_cmd_part <= ~pt;
    o_cmd_wdata <= ~wd;
    #1 rd = i_rsp_valid ? i_rsp_data : 16'hdead;
  endtask
  task automatic poll(output logic [15:0] rd);
    @(posedge i_ref_clk);
    o_serial_poll <= 1'b1;
    @(posedge i_ref_clk);
    o_serial_poll <= 1'b0;
    #1 rd = i_rsp_valid ? i_rsp_data : 16'hdead;
  endtask
endmodule // ssr_host_model

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the status reporting top
// Assumes: host model drives the command port
// Notes:   questionable register modelled bit by bit
`timescale 1ns/1ps
module tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_cal_busy = 1'b0;
  logic [15:0] i_oper_status = 16'h0000;
  logic [15:0] i_ques_status = 16'h0000;
  logic [15:0] i_esr_status = 16'h0000;
  logic        i_err_nonempty = 1'b0;
  logic        i_outbuf_nonempty = 1'b0;
  wire         i_cmd_valid, i_cmd_wr, i_serial_poll;
  wire  [2:0]  i_cmd_reg, i_cmd_part;
  wire  [15:0] i_cmd_wdata, o_rsp_data;
  wire         o_rsp_valid, o_cmd_err, o_srq;
  wire  [7:0]  o_stb, o_sre;
  integer      seed = 64458;
  integer      fails = 0;
  integer      checks_done = 0;
  integer      cyc = 0;
  logic [15:0] ptr = 16'h7fff, ntr = 16'h0, ena = 16'h0, evt = 16'h0;
  logic [15:0] prv = 16'h0, v, x, d;
  logic        q;

  ssr_top uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cal_busy(i_cal_busy),
    .i_oper_status(i_oper_status), .i_ques_status(i_ques_status),
    .i_esr_status(i_esr_status), .i_err_nonempty(i_err_nonempty),
    .i_outbuf_nonempty(i_outbuf_nonempty), .i_cmd_valid(i_cmd_valid),
    .i_cmd_wr(i_cmd_wr), .i_cmd_reg(i_cmd_reg), .i_cmd_part(i_cmd_part),
    .i_cmd_wdata(i_cmd_wdata), .i_serial_poll(i_serial_poll),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_cmd_err(o_cmd_err), .o_srq(o_srq), .o_stb(o_stb), .o_sre(o_sre));
  ssr_host_model host (.i_ref_clk(i_ref_clk), .i_rsp_valid(o_rsp_valid),
    .i_rsp_data(o_rsp_data), .o_cmd_valid(i_cmd_valid),
    .o_cmd_wr(i_cmd_wr), .o_cmd_reg(i_cmd_reg), .o_cmd_part(i_cmd_part),
    .o_cmd_wdata(i_cmd_wdata), .o_serial_poll(i_serial_poll));

  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    host.cmd(1'b0, 3'h4, 3'h0, 16'h0, d);
    chk(d, 16'h0000);
    // reset values, then random write and read-back of the writable parts
    for (int p = 1; p < 5; p++) begin
      host.cmd(1'b0, 3'h1, 3'(p), 16'h0, d);
      chk(d, p == 1 ? 16'h7fff : 16'h0000);
      if (p == 3)
        continue;
      v = 16'($random(seed));
      host.cmd(1'b1, 3'h1, 3'(p), v, d);
      host.cmd(1'b0, 3'h1, 3'(p), 16'h0, d);
      chk(d, v & 16'h7fff);
      if (p == 1) ptr = v & 16'h7fff;
      else if (p == 2) ntr = v & 16'h7fff;
      else ena = v & 16'h7fff;
    end
    host.cmd(1'b1, 3'h1, 3'h0, 16'hffff, d);
    chk({15'h0, o_cmd_err}, 16'h0001);
    host.cmd(1'b0, 3'h1, 3'h0, 16'h0, d);
    chk(d, 16'h0000);
    host.cmd(1'b1, 3'h1, 3'h3, 16'hffff, d);
    chk({15'h0, o_cmd_err}, 16'h0001);
    for (int i = 0; i < 24; i++) begin
      v = (i % 4 == 3) ? prv : 16'($random(seed));
      x = (v & ~prv & ptr | ~v & prv & ntr) & 16'h7fff;
      if (i % 3 == 2) begin
        // transition lands in the clearing read cycle
        fork
          host.cmd(1'b0, 3'h1, 3'h3, 16'h0, d);
          begin
            @(posedge i_ref_clk);
            i_ques_status <= v;
          end
        join
        chk(d, evt);
        evt = x;
      end else begin
        @(posedge i_ref_clk);
        i_ques_status <= v;
        i_esr_status <= 16'($random(seed));
        evt = evt | x;
        host.cmd(1'b0, 3'h1, 3'h0, 16'h0, d);
        chk(d, v & 16'h7fff);
        chk({15'h0, o_stb[3]}, {15'h0, |(evt & ena)});
        if (i % 3 == 0) begin
          host.cmd(1'b0, 3'h1, 3'h3, 16'h0, d);
          chk(d, evt);
          evt = 16'h0;
        end
      end
      prv = v;
    end
    host.cmd(1'b1, 3'h4, 3'h0, 16'hff10, d);
    chk({8'h0, o_sre}, 16'h0010);
    @(posedge i_ref_clk);
    i_outbuf_nonempty <= 1'b1;
    @(posedge i_ref_clk);
    #1 chk({15'h0, o_srq}, 16'h0001);
    q = |(evt & ena);
    host.poll(d);
    chk(d, {8'h0, 3'b010, 1'b1, q, 3'b000});
    @(posedge i_ref_clk);
    i_err_nonempty <= 1'b1;
    i_cal_busy <= 1'b1;
    // bit 0 of the live inputs is low so only the calibration flag sets it
    i_oper_status <= 16'hfffe;
    @(posedge i_ref_clk);
    #1 chk({15'h0, o_srq}, 16'h0000);
    chk({15'h0, o_stb[2]}, 16'h0001);
    host.cmd(1'b0, 3'h0, 3'h0, 16'h0, d);
    chk(d, 16'h7fff);
    host.cmd(1'b0, 3'h6, 3'h0, 16'h0, d);
    chk(d, 16'h0000);
    chk({15'h0, o_cmd_err}, 16'h0001);
    report_and_stop;
  end
endmodule // tb_top

bind ssr_top ssr_top_checker #(.W(W)) chk_i (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_err_nonempty(i_err_nonempty),
  .i_outbuf_nonempty(i_outbuf_nonempty), .i_cmd_valid(i_cmd_valid),
  .i_cmd_wr(i_cmd_wr), .i_cmd_reg(i_cmd_reg), .i_cmd_part(i_cmd_part),
  .i_cmd_wdata(i_cmd_wdata), .i_serial_poll(i_serial_poll),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
  .o_cmd_err(o_cmd_err), .o_srq(o_srq), .o_stb(o_stb), .o_sre(o_sre));
